// ---- design/oscsw_pkg.sv ----
// constants for the oscillator switch and auxiliary clock control block
package oscsw_pkg;
  // apb byte addresses
  localparam logic [7:0] OSCSW_ADDR_OSC_CONTROL = 8'h00;
  localparam logic [7:0] OSCSW_ADDR_PLL_FBD = 8'h04;
  localparam logic [7:0] OSCSW_ADDR_RC_TUNING = 8'h08;
  localparam logic [7:0] OSCSW_ADDR_AUX_CONTROL = 8'h0c;
  localparam logic [7:0] OSCSW_ADDR_UNLOCK = 8'h10;
  localparam logic [7:0] OSCSW_ADDR_STATUS = 8'h14;
  // reset values
  localparam logic [8:0] OSCSW_PLL_MULT_RESET = 9'h030;
  localparam logic [5:0] OSCSW_RC_TRIM_RESET = 6'h00;
  localparam logic [15:0] OSCSW_AUX_RESET = 16'h0000;
  // writable masks
  localparam logic [15:0] OSCSW_AUX_WMASK = 16'h3f80;
  // unlock keys, two words in a row
  localparam logic [15:0] OSCSW_KEY_HIGH_A = 16'h009a;
  localparam logic [15:0] OSCSW_KEY_HIGH_B = 16'h0078;
  localparam logic [15:0] OSCSW_KEY_LOW_A = 16'h0046;
  localparam logic [15:0] OSCSW_KEY_LOW_B = 16'h0057;
  // field positions in osc_control_reg
  localparam int OSCSW_POS_CUR = 12;
  localparam int OSCSW_POS_NEW = 8;
  localparam int OSCSW_POS_LOCK = 5;
  localparam int OSCSW_POS_FAIL = 3;
  localparam int OSCSW_POS_SEC = 1;
  // source codes
  localparam logic [2:0] OSCSW_SRC_FRC = 3'h0;
  localparam logic [2:0] OSCSW_SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] OSCSW_SRC_PRI = 3'h2;
  localparam logic [2:0] OSCSW_SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] OSCSW_SRC_SEC = 3'h4;
  localparam logic [2:0] OSCSW_SRC_LOW_POWER_RC = 3'h5;
  // timing: changeover after new source ready
  localparam logic [3:0] OSCSW_NEW_CLK_WAIT = 4'd10;
  // source enable bit order: frc, pri, sec, low_power_rc, pll
  localparam int OSCSW_NSRC = 5;
  typedef enum logic [4:0] {
    OSCSW_IDLE = 5'b00001,
    OSCSW_CHECK = 5'b00010,
    OSCSW_START = 5'b00100,
    OSCSW_SETTLE = 5'b01000,
    OSCSW_CHANGE = 5'b10000
  } oscsw_state_t;
endpackage

// ---- design/oscsw_ctrl.sv ----
// oscillator switch, fail-safe monitor and auxiliary clock control
`timescale 1ns/1ns
// Behaviour
// R1 - pll multiplier is field plus two, reset 50
// R2 - registers reset only by power-on reset; unlock gate and apb slave use reset
// R3 - rc trim is signed step count
// R4 - bit 13 picks aux oscillator or vco
// R5 - aux oscillator mode, 11 external clock
// R6 - aux output divider 1 to 256
// R7 - bit 7 picks aux reference source
// R8 - switching and monitor need enable config zero
// R9 - switching off: current source from config
// R10 - switching off: request bit held zero
// R11 - software unlocks, writes new, sets request
// R12 - equal sources: clear request, abort
// R13 - valid switch clears lock and fail flag
// R14 - start oscillator, wait timer or lock
// R15 - wait ten new clocks before changeover
// R16 - changeover clears request, copies source
// R17 - old source off, with listed exceptions
// R18 - processor runs during switch
// R19 - software avoids pll to pll switch
// R20 - primary submode fixed by configuration
// R21 - monitor keeps low-power rc running; the code lets it stop in sleep mode unless watchdog_en is set
// R22 - failure traps and falls back to rc
// R23 - pll in use: fall back through pll
// R24 - three-bit source code map
// R25 - fail flag set on failure, clearable
// R26 - lock bit shows pll locked
// R27 - key sequence opens one byte lane
module oscsw_ctrl
  import oscsw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic por,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic switch_enable_cfg,
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic failsafe_cfg,
  input wire logic watchdog_en,
  input wire logic sleep_mode,
  input wire logic [4:0] osc_ready,
  input wire logic pll_locked,
  input wire logic new_clk_tick,
  input wire logic osc_failure,
  output logic [4:0] osc_enable,
  output logic [2:0] sys_clk_sel,
  output logic [9:0] pll_mult,
  output logic [5:0] rc_trim_field,
  output logic aux_div_source_sel,
  output logic [1:0] aux_osc_mode,
  output logic [8:0] aux_div_ratio,
  output logic aux_ref_source_sel,
  output logic [1:0] primary_submode,
  output logic clock_fail_trap
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [8:0] pll_mult_field_reg;
  logic [5:0] rc_trim_reg;
  logic [15:0] aux_reg;
  logic [2:0] current_source_stat_reg;
  logic [2:0] new_source_sel_reg;
  logic switch_request_reg;
  logic clock_fail_flag_reg;
  logic lock_stat_reg;
  logic secondary_osc_enable_reg;
  logic cfg_loaded_reg;
  logic [1:0] key_stage_reg;
  logic open_high_reg;
  logic open_low_reg;
  logic [3:0] settle_cnt_reg;
  logic [4:0] old_mask_reg;
  oscsw_state_t state_reg;
  logic switching_on;
  logic monitor_on;
  logic wr_acc;
  logic [15:0] wd;
  logic [15:0] osc_control_rd;
  logic fail_event;
  logic fail_q_reg;
  logic [4:0] src_need;
  logic [4:0] new_need;
  logic new_uses_pll;
  logic cur_uses_pll;
  logic new_ready;
  logic [2:0] fallback_src;
  assign wd = pwdata[15:0];
  assign wr_acc = psel && penable && pwrite;
  // R8 config gate
  assign switching_on = !switch_enable_cfg;
  assign monitor_on = switching_on && failsafe_cfg;
  // R20 submode is config only
  assign new_uses_pll = (new_source_sel_reg == OSCSW_SRC_FRC_PLL) || (new_source_sel_reg == OSCSW_SRC_PRI_PLL);
  assign cur_uses_pll = (current_source_stat_reg == OSCSW_SRC_FRC_PLL) ||
                        (current_source_stat_reg == OSCSW_SRC_PRI_PLL);
  // R23 fallback keeps pll
  assign fallback_src = cur_uses_pll ? OSCSW_SRC_FRC_PLL : OSCSW_SRC_FRC;
  // one trap per rising failure, not per cycle of the level
  assign fail_event = monitor_on && osc_failure && !fail_q_reg && !sleep_mode && cfg_loaded_reg;

  // R24 source code to oscillator needs
  function automatic logic [4:0] oscsw_need(input logic [2:0] src);
    logic [4:0] n;
    n = 5'b00000;
    unique case (src)
      OSCSW_SRC_FRC_PLL: n = 5'b10001;
      OSCSW_SRC_PRI: n = 5'b00010;
      OSCSW_SRC_PRI_PLL: n = 5'b10010;
      OSCSW_SRC_SEC: n = 5'b00100;
      OSCSW_SRC_LOW_POWER_RC: n = 5'b01000;
      default: n = 5'b00001;
    endcase
    return n;
  endfunction
  assign src_need = oscsw_need(current_source_stat_reg);
  assign new_need = oscsw_need(new_source_sel_reg);
  // R14 ready means oscillator ready and, for pll sources, lock seen
  assign new_ready = ((osc_ready & new_need & 5'b01111) == (new_need & 5'b01111)) &&
                     (!new_uses_pll || pll_locked);

  // ----------------------------------------
  // unlock gate
  // ----------------------------------------
  // R27 key pair opens one lane, one write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      key_stage_reg <= 2'd0;
      open_high_reg <= 1'b0;
      open_low_reg <= 1'b0;
    end else if (wr_acc && paddr == OSCSW_ADDR_UNLOCK) begin
      open_high_reg <= 1'b0;
      open_low_reg <= 1'b0;
      if (key_stage_reg == 2'd0 && wd == OSCSW_KEY_HIGH_A) begin
        key_stage_reg <= 2'd1;
      end else if (key_stage_reg == 2'd0 && wd == OSCSW_KEY_LOW_A) begin
        key_stage_reg <= 2'd2;
      end else if (key_stage_reg == 2'd1 && wd == OSCSW_KEY_HIGH_B) begin
        key_stage_reg <= 2'd0;
        open_high_reg <= 1'b1;
      end else if (key_stage_reg == 2'd2 && wd == OSCSW_KEY_LOW_B) begin
        key_stage_reg <= 2'd0;
        open_low_reg <= 1'b1;
      end else begin
        key_stage_reg <= 2'd0;
      end
    end else if (wr_acc) begin
      key_stage_reg <= 2'd0;
      open_high_reg <= 1'b0;
      open_low_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // plain configuration registers
  // ----------------------------------------
  // R2 only power-on reset clears these
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      pll_mult_field_reg <= OSCSW_PLL_MULT_RESET;
      rc_trim_reg <= OSCSW_RC_TRIM_RESET;
      aux_reg <= OSCSW_AUX_RESET;
    end else if (wr_acc) begin
      // R1 nine-bit multiplier field
      if (paddr == OSCSW_ADDR_PLL_FBD) begin
        pll_mult_field_reg <= wd[8:0];
      end
      // R3 six-bit signed trim
      if (paddr == OSCSW_ADDR_RC_TUNING) begin
        rc_trim_reg <= wd[5:0];
      end
      if (paddr == OSCSW_ADDR_AUX_CONTROL) begin
        aux_reg <= wd & OSCSW_AUX_WMASK;
      end
    end
  end

  // ----------------------------------------
  // switch sequencer and control register
  // ----------------------------------------
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      cfg_loaded_reg <= 1'b0;
      current_source_stat_reg <= OSCSW_SRC_FRC;
      new_source_sel_reg <= OSCSW_SRC_FRC;
      switch_request_reg <= 1'b0;
      clock_fail_flag_reg <= 1'b0;
      secondary_osc_enable_reg <= 1'b0;
      settle_cnt_reg <= 4'd0;
      old_mask_reg <= 5'b00000;
      clock_fail_trap <= 1'b0;
      state_reg <= OSCSW_IDLE;
    end else if (!cfg_loaded_reg) begin
      // R9 sources taken from config after release
      cfg_loaded_reg <= 1'b1;
      current_source_stat_reg <= initial_source_cfg;
      new_source_sel_reg <= initial_source_cfg;
    end else begin
      clock_fail_trap <= 1'b0;
      if (wr_acc && paddr == OSCSW_ADDR_OSC_CONTROL) begin
        if (open_high_reg && switching_on && state_reg == OSCSW_IDLE) begin
          new_source_sel_reg <= wd[OSCSW_POS_NEW +: 3];
        end
        if (open_low_reg) begin
          secondary_osc_enable_reg <= wd[OSCSW_POS_SEC];
          // R25 software clears the fail flag
          if (!wd[OSCSW_POS_FAIL]) begin
            clock_fail_flag_reg <= 1'b0;
          end
          // R10 request ignored while switching off
          if (wd[0] && switching_on && state_reg == OSCSW_IDLE) begin
            switch_request_reg <= 1'b1;
            state_reg <= OSCSW_CHECK;
          end
        end
      end
      unique case (state_reg)
        OSCSW_IDLE: begin
        end
        OSCSW_CHECK: begin
          // R12 redundant switch aborts
          if (new_source_sel_reg == current_source_stat_reg) begin
            switch_request_reg <= 1'b0;
            state_reg <= OSCSW_IDLE;
          end else begin
            // R13 clear fail flag at start
            clock_fail_flag_reg <= 1'b0;
            old_mask_reg <= src_need;
            state_reg <= OSCSW_START;
          end
        end
        OSCSW_START: begin
          settle_cnt_reg <= 4'd0;
          if (new_ready) begin
            state_reg <= OSCSW_SETTLE;
          end
        end
        OSCSW_SETTLE: begin
          // R15 ten new-clock ticks
          if (new_clk_tick) begin
            settle_cnt_reg <= settle_cnt_reg + 4'd1;
            if (settle_cnt_reg == OSCSW_NEW_CLK_WAIT - 4'd1) begin
              state_reg <= OSCSW_CHANGE;
            end
          end
        end
        OSCSW_CHANGE: begin
          // R16 changeover completes
          current_source_stat_reg <= new_source_sel_reg;
          switch_request_reg <= 1'b0;
          state_reg <= OSCSW_IDLE;
        end
        default: state_reg <= OSCSW_IDLE;
      endcase
      // R22 failure traps and falls back
      if (fail_event) begin
        clock_fail_flag_reg <= 1'b1;
        clock_fail_trap <= 1'b1;
        current_source_stat_reg <= fallback_src;
        new_source_sel_reg <= fallback_src;
        switch_request_reg <= 1'b0;
        state_reg <= OSCSW_IDLE;
      end
      // R10 request forced low
      if (!switching_on) begin
        switch_request_reg <= 1'b0;
        state_reg <= OSCSW_IDLE;
      end
    end
  end

  // R26 lock status, cleared at switch start
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      lock_stat_reg <= 1'b0;
    end else if (state_reg == OSCSW_CHECK && new_source_sel_reg != current_source_stat_reg) begin
      // R13 lock cleared
      lock_stat_reg <= 1'b0;
    end else begin
      lock_stat_reg <= pll_locked && osc_enable[4];
    end
  end

  // R22 failure edge detect
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      fail_q_reg <= 1'b0;
    end else begin
      fail_q_reg <= osc_failure;
    end
  end

  // ----------------------------------------
  // oscillator enables and outputs
  // ----------------------------------------
  // R17 old source off, exceptions kept
  // R21 monitor keeps low-power rc on outside sleep mode; watchdog_en keeps it on in sleep too
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      osc_enable <= 5'b00001;
    end else begin
      osc_enable <= src_need |
                    // R14 new oscillator powered up
                    ((state_reg == OSCSW_START || state_reg == OSCSW_SETTLE) ? (new_need | old_mask_reg) : 5'b00000) |
                    (secondary_osc_enable_reg ? 5'b00100 : 5'b00000) |
                    (((monitor_on && !sleep_mode) || watchdog_en) ? 5'b01000 : 5'b00000);
    end
  end

  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      sys_clk_sel <= OSCSW_SRC_FRC;
      pll_mult <= 10'd0;
      rc_trim_field <= OSCSW_RC_TRIM_RESET;
      aux_div_source_sel <= 1'b0;
      aux_osc_mode <= 2'b00;
      aux_div_ratio <= 9'd256;
      aux_ref_source_sel <= 1'b0;
      primary_submode <= 2'b00;
    end else begin
      sys_clk_sel <= current_source_stat_reg;
      // R1 multiplier is field plus two
      pll_mult <= {1'b0, pll_mult_field_reg} + 10'd2;
      rc_trim_field <= rc_trim_reg;
      // R4 divider source
      aux_div_source_sel <= aux_reg[13];
      // R5 aux oscillator mode
      aux_osc_mode <= aux_reg[12:11];
      // R6 output divide ratio
      aux_div_ratio <= (aux_reg[10:8] == 3'b000) ? 9'd256 : 9'(9'd64 >> (aux_reg[10:8] - 3'd1));
      // R7 reference source
      aux_ref_source_sel <= aux_reg[7];
      // R20 submode from configuration
      primary_submode <= primary_submode_cfg;
    end
  end

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  assign osc_control_rd = {1'b0, current_source_stat_reg, 1'b0, new_source_sel_reg, 2'b00, lock_stat_reg,
                           1'b0, clock_fail_flag_reg, 1'b0, secondary_osc_enable_reg, switch_request_reg};

  // R18 bus served mid-switch
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          OSCSW_ADDR_OSC_CONTROL: prdata <= {16'h0000, osc_control_rd};
          OSCSW_ADDR_PLL_FBD: prdata <= {23'h000000, pll_mult_field_reg};
          OSCSW_ADDR_RC_TUNING: prdata <= {26'h0000000, rc_trim_reg};
          OSCSW_ADDR_AUX_CONTROL: prdata <= {16'h0000, aux_reg};
          OSCSW_ADDR_UNLOCK: prdata <= {30'h00000000, key_stage_reg};
          OSCSW_ADDR_STATUS: prdata <= {27'h0000000, state_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // oscsw_ctrl

// ---- tb/oscsw_monitor.sv ----
// checker for the oscillator switch block
`timescale 1ns/1ns
module oscsw_monitor
  import oscsw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic por,
  input wire logic switch_enable_cfg,
  input wire logic failsafe_cfg,
  input wire logic watchdog_en,
  input wire logic sleep_mode,
  input wire logic new_clk_tick,
  input wire logic osc_failure,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic [4:0] osc_enable,
  input wire logic [2:0] sys_clk_sel,
  input wire logic [9:0] pll_mult,
  input wire logic [8:0] aux_div_ratio,
  input wire logic [1:0] primary_submode,
  input wire logic clock_fail_trap
);
  // ----------------------------------------
  // helpers: age since por, ticks since change
  // ----------------------------------------
  logic [2:0] age_reg;
  logic [3:0] tick_reg;
  logic [2:0] sel_q_reg;
  logic fs_on;
  logic aged;
  assign fs_on = watchdog_en || (failsafe_cfg && !switch_enable_cfg && !sleep_mode);
  assign aged = age_reg == 3'h7;
  always_ff @(posedge mclk or posedge por) begin
    if (por) age_reg <= 3'h0;
    else if (!aged) age_reg <= age_reg + 3'h1;
  end
  always_ff @(posedge mclk or posedge por) begin
    if (por) sel_q_reg <= 3'h0;
    else sel_q_reg <= sys_clk_sel;
  end
  always_ff @(posedge mclk or posedge por) begin
    if (por) tick_reg <= 4'h0;
    else if (sys_clk_sel != sel_q_reg) tick_reg <= 4'h0;
    else if (new_clk_tick && tick_reg != 4'hf) tick_reg <= tick_reg + 4'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (por || reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_mult_range: assert property (
    aged |-> pll_mult >= 10'd2 && pll_mult <= 10'd513) else $error("pll_mult out of range");
  a_ratio_legal: assert property (
    $onehot(aux_div_ratio) && !aux_div_ratio[7]) else $error("aux ratio illegal");
  a_locked_hold: assert property (
    aged && switch_enable_cfg && $past(switch_enable_cfg) |-> $stable(sys_clk_sel) && !clock_fail_trap)
    else $error("source moved while switching off");
  a_trap_cause: assert property (
    clock_fail_trap |-> $past(osc_failure) && !$past(switch_enable_cfg) && $past(failsafe_cfg) && !$past(sleep_mode))
    else $error("trap without cause");
  a_trap_pulse: assert property (
    clock_fail_trap |=> !clock_fail_trap) else $error("trap longer than one cycle");
  a_fail_to_rc: assert property (
    clock_fail_trap && $past(sys_clk_sel) == OSCSW_SRC_PRI |-> ##[0:1] sys_clk_sel == OSCSW_SRC_FRC)
    else $error("no fallback to rc");
  a_fail_keep_pll: assert property (
    clock_fail_trap && $past(sys_clk_sel) == OSCSW_SRC_PRI_PLL |-> ##[0:1] sys_clk_sel == OSCSW_SRC_FRC_PLL)
    else $error("no fallback through pll");
  a_switch_ticks: assert property (
    aged && sys_clk_sel != sel_q_reg && !$past(clock_fail_trap) |-> tick_reg >= 4'd10)
    else $error("changeover too early");
  a_low_power_rc_on: assert property (
    aged && $past(fs_on) && $past(fs_on, 2) && $past(fs_on, 3) |-> osc_enable[3]) else $error("low-power rc off");
  a_submode_copy: assert property (
    aged |-> primary_submode == $past(primary_submode_cfg)) else $error("submode not copied");
  c_trap: cover property (clock_fail_trap);
  c_pll_src: cover property (sys_clk_sel == OSCSW_SRC_PRI_PLL);
  c_change: cover property (aged && sys_clk_sel != sel_q_reg && !$past(clock_fail_trap));
endmodule // oscsw_monitor

bind oscsw_ctrl oscsw_monitor u_mon (.mclk, .reset, .por, .switch_enable_cfg, .failsafe_cfg, .watchdog_en,
  .sleep_mode, .new_clk_tick, .osc_failure, .primary_submode_cfg, .osc_enable, .sys_clk_sel, .pll_mult,
  .aux_div_ratio, .primary_submode, .clock_fail_trap);

// ---- tb/oscsw_osc_model.sv ----
// oscillator sources and pll facing the switch block
`timescale 1ns/1ns
module oscsw_osc_model (
  input wire logic mclk,
  input wire logic por,
  input wire logic slow,
  input wire logic [4:0] osc_enable,
  output logic [4:0] osc_ready,
  output logic pll_locked,
  output logic new_clk_tick
);
  logic [4:0] en_q [8];
  logic [1:0] div_reg;
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      for (int i = 0; i < 8; i++) en_q[i] <= 5'h0;
    end else begin
      en_q[0] <= osc_enable;
      for (int i = 1; i < 8; i++) en_q[i] <= en_q[i - 1];
    end
  end
  assign osc_ready = osc_enable & (slow ? en_q[7] : en_q[2]);
  assign pll_locked = osc_ready[4] & en_q[7][4];
  always_ff @(posedge mclk or posedge por) begin
    if (por) div_reg <= 2'h0;
    else div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
  end
  assign new_clk_tick = div_reg == 2'h2;
endmodule // oscsw_osc_model

// ---- tb/oscsw_ctrl_tb.sv ----
// self-checking bench for the oscillator switch block
`timescale 1ns/1ns
module oscsw_ctrl_tb
  import oscsw_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, por = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pll_locked, new_clk_tick, aux_div_source_sel, aux_ref_source_sel, clock_fail_trap;
  logic switch_enable_cfg = 1'b1, failsafe_cfg = 1'b1, watchdog_en = 1'b0, sleep_mode = 1'b0, osc_failure = 1'b0;
  logic [2:0] initial_source_cfg = OSCSW_SRC_PRI, sys_clk_sel, k;
  logic [1:0] primary_submode_cfg = 2'h2, aux_osc_mode, primary_submode;
  logic [4:0] osc_ready, osc_enable;
  logic [9:0] pll_mult;
  logic [5:0] rc_trim_field;
  logic [8:0] aux_div_ratio;
  logic [15:0] v;
  int n_errors = 0, checks_done = 0, traps = 0;

  oscsw_ctrl DUT (.mclk, .reset, .por, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .switch_enable_cfg, .initial_source_cfg, .primary_submode_cfg, .failsafe_cfg, .watchdog_en, .sleep_mode,
    .osc_ready, .pll_locked, .new_clk_tick, .osc_failure, .osc_enable, .sys_clk_sel, .pll_mult, .rc_trim_field,
    .aux_div_source_sel, .aux_osc_mode, .aux_div_ratio, .aux_ref_source_sel, .primary_submode, .clock_fail_trap);
  oscsw_osc_model u_osc (.mclk, .por, .slow, .osc_enable, .osc_ready, .pll_locked, .new_clk_tick);

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (clock_fail_trap === 1'b1) traps <= traps + 1;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, exp, rd & m);
  endtask
  task automatic osc(input logic hi, input logic [15:0] d);
    apb(1'b1, OSCSW_ADDR_UNLOCK, {16'h0, hi ? OSCSW_KEY_HIGH_A : OSCSW_KEY_LOW_A});
    apb(1'b1, OSCSW_ADDR_UNLOCK, {16'h0, hi ? OSCSW_KEY_HIGH_B : OSCSW_KEY_LOW_B});
    apb(1'b1, OSCSW_ADDR_OSC_CONTROL, {16'h0, d});
  endtask
  task automatic switch_to(input logic [2:0] s);
    osc(1'b1, {5'h0, s, 8'h00});
    osc(1'b0, 16'h0009);
    repeat (300) if (sys_clk_sel !== s) @(posedge mclk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    por <= 1'b0;
    repeat (2) @(posedge mclk);
    rdc(OSCSW_ADDR_PLL_FBD, 32'hffffffff, 32'h30, "pll_fbd");
    check("pll_mult", 32'd50, {22'h0, pll_mult});
    rdc(OSCSW_ADDR_RC_TUNING, 32'hffffffff, 32'h0, "rc_tun");
    rdc(OSCSW_ADDR_AUX_CONTROL, 32'hffffffff, 32'h0, "aux");
    check("ratio", 32'd256, {23'h0, aux_div_ratio});
    apb(1'b1, OSCSW_ADDR_PLL_FBD, 32'hffffffff);
    rdc(OSCSW_ADDR_PLL_FBD, 32'hffffffff, 32'h1ff, "pll_fbd");
    check("pll_mult", 32'd513, {22'h0, pll_mult});
    apb(1'b1, OSCSW_ADDR_RC_TUNING, 32'h0000ffe0);
    rdc(OSCSW_ADDR_RC_TUNING, 32'hffffffff, 32'h20, "rc_tun");
    check("trim", 32'h20, {26'h0, rc_trim_field});
    for (int c = 0; c < 8; c++) begin
      k = c[2:0];
      v = {2'b11, k[0], k[1:0], k, k[1], 7'h7f};
      apb(1'b1, OSCSW_ADDR_AUX_CONTROL, {16'h0, v});
      rdc(OSCSW_ADDR_AUX_CONTROL, 32'hffffffff, {16'h0, v & 16'h3f80}, "aux");
      check("ratio", (c == 0) ? 32'd256 : 32'd1 << (7 - c), {23'h0, aux_div_ratio});
      check("aux_bits", {28'h0, k[0], k[1:0], k[1]},
        {28'h0, aux_div_source_sel, aux_osc_mode, aux_ref_source_sel});
    end
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rdc(OSCSW_ADDR_PLL_FBD, 32'hffffffff, 32'h1ff, "pll_keep");
    apb(1'b0, 8'h18, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    check("submode", 32'h2, {30'h0, primary_submode});
    switch_to(OSCSW_SRC_FRC);
    check("cur_src", OSCSW_SRC_PRI, {29'h0, sys_clk_sel});
    rdc(OSCSW_ADDR_OSC_CONTROL, 32'h7029, 32'h2000, "osc_ctl");
    switch_enable_cfg <= 1'b0;
    switch_to(OSCSW_SRC_PRI);
    rdc(OSCSW_ADDR_OSC_CONTROL, 32'h7001, 32'h2000, "abort");
    slow <= 1'b1;
    switch_to(OSCSW_SRC_PRI_PLL);
    check("cur_src", OSCSW_SRC_PRI_PLL, {29'h0, sys_clk_sel});
    rdc(OSCSW_ADDR_OSC_CONTROL, 32'h7021, 32'h3020, "osc_ctl");
    osc_failure <= 1'b1;
    repeat (3) @(posedge mclk);
    osc_failure <= 1'b0;
    check("fallback", OSCSW_SRC_FRC_PLL, {29'h0, sys_clk_sel});
    rdc(OSCSW_ADDR_OSC_CONTROL, 32'h7008, 32'h1008, "fail_flag");
    switch_to(OSCSW_SRC_FRC);
    rdc(OSCSW_ADDR_OSC_CONTROL, 32'h7009, 32'h0000, "osc_ctl");
    check("enables", 32'h08, {27'h0, osc_enable & 5'h1e});
    slow <= 1'b0;
    switch_to(OSCSW_SRC_PRI);
    check("cur_src", OSCSW_SRC_PRI, {29'h0, sys_clk_sel});
    osc_failure <= 1'b1;
    repeat (3) @(posedge mclk);
    osc_failure <= 1'b0;
    check("fallback", OSCSW_SRC_FRC, {29'h0, sys_clk_sel});
    check("traps", 32'd2, traps);
    sleep_mode <= 1'b1;
    osc_failure <= 1'b1;
    repeat (3) @(posedge mclk);
    check("sleep_low_power_rc", 32'h0, {31'h0, osc_enable[3]});
    sleep_mode <= 1'b0;
    osc_failure <= 1'b0;
    watchdog_en <= 1'b1;
    repeat (2) @(posedge mclk);
    check("wdt_low_power_rc", 32'h1, {31'h0, osc_enable[3]});
    check("traps_sleep", 32'd2, traps);
    osc(1'b0, 16'h0000);
    rdc(OSCSW_ADDR_OSC_CONTROL, 32'h0008, 32'h0, "fail_clr");
    finish_test();
  end
endmodule // oscsw_ctrl_tb
